// *** verilog/fsc_fault_status.sv ***
`timescale 1ns/100ps

// Overview of operation
// - divide flag set only for zero-divisor divide with divide trapping enabled
// - divide fault stacks the divide instruction's own address
// - single misaligned access sets flag only when misalign trapping is enabled
// - misaligned multi and dual load or store always fault
// - any coprocessor access sets the no-coprocessor flag
// - illegal return-code load into pc sets flag, stacks offending address
// - illegal execution state use sets flag, but not for undefined instructions
// - undecodable instruction sets undefined flag and stacks its address
// - usage and hard fault bits sticky, cleared by reset or writing one
// - escalation of configurable fault to hard fault sets bit 30
// - vector fetch bus fault sets bit 1, goes hard, stacks preempted pc
// - memory fault address register holds full faulting address when valid
// - misaligned split access records the actual faulting piece address
// - bus fault address register holds full faulting address when valid
// - misaligned bus fault records the address the instruction requested
// - misaligned register accesses are unsupported
// - memory status bit 7 marks the memory fault address as valid
// - bus status bit 7 set on known-address bus fault, known-address memory fault clears it
// - usage status reachable as upper halfword of combined status word
module fsc_fault_status
	import fsc_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic [7:0]  avs_address_i,
	input  wire logic        avs_read_i,
	input  wire logic        avs_write_i,
	input  wire logic [3:0]  avs_byteenable_i,
	input  wire logic [31:0] avs_writedata_i,
	output logic      [31:0] avs_readdata_o,
	output logic             avs_waitrequest_o,
	input  wire fsc_evt_t    evt_i,
	output fsc_rsp_t         rsp_o,
	output logic             div_zero_trap_en_o,
	output logic             misalign_trap_en_o
);

	// ========================================
	// state
	fsc_bus_state_t state_ff;
	fsc_bus_state_t nxt_state;
	logic [31:0]    config_fault_status_ff;
	logic [31:0]    hard_fault_status_ff;
	logic [31:0]    memmanage_fault_address_ff;
	logic [31:0]    bus_fault_address_ff;
	logic           div_en_ff;
	logic           mis_en_ff;
	logic [31:0]    rdata_ff;
	logic           wait_ff;
	fsc_rsp_t       rsp_ff;

	logic [31:0] config_fault_status_set;
	logic [31:0] config_fault_status_clr;
	logic [31:0] hard_fault_status_set;
	logic [31:0] hard_fault_status_clr;
	logic [31:0] bmask;
	logic [31:0] rd_mux;
	logic        wr_go;
	logic        full_word;
	logic        usage_any;
	logic        mm_valid_set;
	logic        bus_valid_set;

	// ========================================
	// bus handshake
	// one wait cycle; read data are registered at the same edge that drops waitrequest
	always_comb begin
		case (state_ff)
			FSC_IDLE: begin
				if (avs_read_i || avs_write_i) begin
					nxt_state = FSC_ACK;
				end else begin
					nxt_state = FSC_IDLE;
				end
			end
			FSC_ACK: nxt_state = FSC_IDLE;
			default: nxt_state = FSC_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state_ff <= FSC_IDLE;
			wait_ff  <= 1'b1;
		end else begin
			state_ff <= nxt_state;
			wait_ff  <= (nxt_state != FSC_ACK);
		end
	end

	assign wr_go     = (state_ff == FSC_ACK) && avs_write_i;
	assign full_word = (avs_byteenable_i == 4'hF);

	// per-lane mask; status word alone honours partial lanes
	always_comb begin
		bmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
			{8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
	end

	// ========================================
	// read mux
	always_comb begin
		case (avs_address_i)
			FSC_CCR_OFS: begin
				rd_mux = 32'h0000_0000;
				rd_mux[FSC_CCR_DIVZERO_BIT]  = div_en_ff;
				rd_mux[FSC_CCR_MISALIGN_BIT] = mis_en_ff;
			end
			FSC_CONFIG_FAULT_STATUS_OFS:  rd_mux = config_fault_status_ff & FSC_CONFIG_FAULT_STATUS_IMPL;
			FSC_HARD_FAULT_STATUS_OFS:  rd_mux = hard_fault_status_ff & FSC_HARD_FAULT_STATUS_IMPL;
			FSC_MEMMANAGE_FAULT_ADDRESS_OFS: rd_mux = memmanage_fault_address_ff;
			FSC_BUS_FAULT_ADDRESS_OFS:  rd_mux = bus_fault_address_ff;
			default:       rd_mux = 32'h0000_0000;
		endcase
	end

	// snapshot taken at the edge that enters the answer cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_ff <= 32'h0000_0000;
		end else if (state_ff == FSC_IDLE && avs_read_i) begin
			rdata_ff <= rd_mux;
		end
	end

	// ========================================
	// trap enables
	// partial writes to word-only registers are dropped, not merged
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			div_en_ff <= FSC_CCR_RESET[1];
			mis_en_ff <= FSC_CCR_RESET[0];
		end else if (wr_go && full_word
			&& avs_address_i == FSC_CCR_OFS) begin
			div_en_ff <= avs_writedata_i[FSC_CCR_DIVZERO_BIT];
			mis_en_ff <= avs_writedata_i[FSC_CCR_MISALIGN_BIT];
		end
	end

	// ========================================
	// fault set terms
	assign mm_valid_set  = evt_i.mm_addr_known;
	assign bus_valid_set = evt_i.bus_addr_known;

	always_comb begin
		config_fault_status_set = 32'h0000_0000;
		config_fault_status_set[FSC_MM_LSB +: 8]  = evt_i.mm_cause;
		config_fault_status_set[FSC_BUS_LSB +: 8] = evt_i.bus_cause;
		config_fault_status_set[FSC_MM_LSB + FSC_VALID_BIT]  = mm_valid_set;
		config_fault_status_set[FSC_BUS_LSB + FSC_VALID_BIT] = bus_valid_set;
		config_fault_status_set[FSC_USAGE_LSB + FSC_DIVZERO_BIT] =
			evt_i.div_zero && div_en_ff;
		config_fault_status_set[FSC_USAGE_LSB + FSC_MISALIGN_BIT] =
			(evt_i.misalign && mis_en_ff)
			|| evt_i.misalign_multi;
		config_fault_status_set[FSC_USAGE_LSB + FSC_NOCOPRO_BIT] = evt_i.copro;
		config_fault_status_set[FSC_USAGE_LSB + FSC_BADPC_BIT]   = evt_i.bad_pc;
		config_fault_status_set[FSC_USAGE_LSB + FSC_BADST_BIT]   =
			evt_i.bad_state && !evt_i.undef;
		config_fault_status_set[FSC_USAGE_LSB + FSC_UNDEF_BIT]   = evt_i.undef;
	end

	// a fault with a known address of the other kind drops the stale valid
	always_comb begin
		config_fault_status_clr = 32'h0000_0000;
		if (wr_go && avs_address_i == FSC_CONFIG_FAULT_STATUS_OFS) begin
			config_fault_status_clr = avs_writedata_i & bmask;
		end
		config_fault_status_clr[FSC_MM_LSB + FSC_VALID_BIT] =
			config_fault_status_clr[FSC_MM_LSB + FSC_VALID_BIT] || bus_valid_set;
		config_fault_status_clr[FSC_BUS_LSB + FSC_VALID_BIT] =
			config_fault_status_clr[FSC_BUS_LSB + FSC_VALID_BIT] || mm_valid_set;
	end

	always_comb begin
		hard_fault_status_set = 32'h0000_0000;
		hard_fault_status_set[FSC_HF_DEBUG_BIT] = evt_i.debug_evt;
		hard_fault_status_set[FSC_HF_ESC_BIT]   = evt_i.escalate;
		hard_fault_status_set[FSC_HF_VEC_BIT]   = evt_i.vec_fetch;
		hard_fault_status_clr = 32'h0000_0000;
		if (wr_go && full_word && avs_address_i == FSC_HARD_FAULT_STATUS_OFS) begin
			hard_fault_status_clr = avs_writedata_i;
		end
	end

	// ========================================
	// sticky bits, one flop per implemented bit
	// set beats a same-cycle clear so no fault is lost
	genvar gi;
	generate
		for (gi = 0; gi < 32; gi = gi + 1) begin : g_sticky
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					config_fault_status_ff[gi] <= FSC_CONFIG_FAULT_STATUS_RESET[gi];
					hard_fault_status_ff[gi] <= FSC_HARD_FAULT_STATUS_RESET[gi];
				end else begin
					config_fault_status_ff[gi] <= FSC_CONFIG_FAULT_STATUS_IMPL[gi] && (config_fault_status_set[gi]
						|| (config_fault_status_ff[gi] && !config_fault_status_clr[gi]));
					hard_fault_status_ff[gi] <= FSC_HARD_FAULT_STATUS_IMPL[gi] && (hard_fault_status_set[gi]
						|| (hard_fault_status_ff[gi] && !hard_fault_status_clr[gi]));
				end
			end
		end
	endgenerate

	// ========================================
	// fault address capture
	// hardware capture wins over a software write in the same cycle
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			memmanage_fault_address_ff <= FSC_ADDR_RESET;
		end else if (mm_valid_set) begin
			memmanage_fault_address_ff <= evt_i.mm_addr;
		end else if (wr_go && full_word
			&& avs_address_i == FSC_MEMMANAGE_FAULT_ADDRESS_OFS) begin
			memmanage_fault_address_ff <= avs_writedata_i;
		end
	end

	// core supplies the requested address, not the faulting piece
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bus_fault_address_ff <= FSC_ADDR_RESET;
		end else if (bus_valid_set) begin
			bus_fault_address_ff <= evt_i.bus_req_addr;
		end else if (wr_go && full_word
			&& avs_address_i == FSC_BUS_FAULT_ADDRESS_OFS) begin
			bus_fault_address_ff <= avs_writedata_i;
		end
	end

	// ========================================
	// fault entry report to the core
	assign usage_any = config_fault_status_set[FSC_USAGE_LSB +: 16] != 16'h0000;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rsp_ff <= '0;
		end else begin
			rsp_ff.usage_take <= usage_any && !evt_i.vec_fetch;
			rsp_ff.hard_take  <= evt_i.vec_fetch || evt_i.escalate;
			if (evt_i.vec_fetch) begin
				rsp_ff.stacked_pc <= evt_i.preempt_pc;
			end else if (usage_any) begin
				rsp_ff.stacked_pc <= evt_i.instr_pc;
			end
		end
	end

	// ========================================
	// outputs
	// bus offers no unaligned form, so no misaligned path exists
	assign avs_readdata_o     = rdata_ff;
	assign avs_waitrequest_o  = wait_ff;
	assign rsp_o              = rsp_ff;
	assign div_zero_trap_en_o = div_en_ff;
	assign misalign_trap_en_o = mis_en_ff;

endmodule : fsc_fault_status

// *** verilog/fsc_pkg.sv ***
package fsc_pkg;

	// ========================================
	// register byte offsets
	localparam logic [7:0] FSC_CCR_OFS   = 8'h14;
	localparam logic [7:0] FSC_CONFIG_FAULT_STATUS_OFS  = 8'h28;
	localparam logic [7:0] FSC_HARD_FAULT_STATUS_OFS  = 8'h2C;
	localparam logic [7:0] FSC_MEMMANAGE_FAULT_ADDRESS_OFS = 8'h34;
	localparam logic [7:0] FSC_BUS_FAULT_ADDRESS_OFS  = 8'h38;

	// ========================================
	// config_control_reg fields
	localparam int         FSC_CCR_MISALIGN_BIT = 3;
	localparam int         FSC_CCR_DIVZERO_BIT  = 4;
	localparam logic [1:0] FSC_CCR_RESET        = 2'h0;

	// ========================================
	// config_fault_status layout
	localparam int FSC_MM_LSB      = 0;
	localparam int FSC_BUS_LSB     = 8;
	localparam int FSC_USAGE_LSB   = 16;
	localparam int FSC_VALID_BIT   = 7;
	localparam int FSC_DIVZERO_BIT = 9;
	localparam int FSC_MISALIGN_BIT = 8;
	localparam int FSC_NOCOPRO_BIT = 3;
	localparam int FSC_BADPC_BIT   = 2;
	localparam int FSC_BADST_BIT   = 1;
	localparam int FSC_UNDEF_BIT   = 0;
	localparam logic [31:0] FSC_CONFIG_FAULT_STATUS_IMPL  = 32'h030F_9F9B;
	localparam logic [31:0] FSC_CONFIG_FAULT_STATUS_RESET = 32'h0000_0000;

	// ========================================
	// hard_fault_status layout
	localparam int          FSC_HF_DEBUG_BIT = 31;
	localparam int          FSC_HF_ESC_BIT   = 30;
	localparam int          FSC_HF_VEC_BIT   = 1;
	localparam logic [31:0] FSC_HARD_FAULT_STATUS_IMPL    = 32'hC000_0002;
	localparam logic [31:0] FSC_HARD_FAULT_STATUS_RESET   = 32'h0000_0000;
	localparam logic [31:0] FSC_ADDR_RESET   = 32'h0000_0000;

	// ========================================
	// core fault reports, one cycle each
	typedef struct packed {
		logic        div_zero;
		logic        misalign;
		logic        misalign_multi;
		logic        copro;
		logic        bad_pc;
		logic        bad_state;
		logic        undef;
		logic        escalate;
		logic        vec_fetch;
		logic        debug_evt;
		logic [7:0]  mm_cause;
		logic        mm_addr_known;
		logic [31:0] mm_addr;
		logic [7:0]  bus_cause;
		logic        bus_addr_known;
		logic [31:0] bus_req_addr;
		logic [31:0] instr_pc;
		logic [31:0] preempt_pc;
	} fsc_evt_t;

	typedef struct packed {
		logic        usage_take;
		logic        hard_take;
		logic [31:0] stacked_pc;
	} fsc_rsp_t;

	typedef enum logic [1:0] {
		FSC_IDLE = 2'b00,
		FSC_ACK  = 2'b01
	} fsc_bus_state_t;

endpackage : fsc_pkg

// *** verif/fsc_fault_status_checker.sv ***
`timescale 1ns/100ps
// ==========
// port checks
module fsc_checker
	import fsc_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic [7:0]  avs_address_i,
	input wire logic        avs_read_i,
	input wire logic        avs_write_i,
	input wire logic [31:0] avs_readdata_o,
	input wire logic        avs_waitrequest_o,
	input wire fsc_evt_t    evt_i,
	input wire fsc_rsp_t    rsp_o
);
	// stacking happens only on these reports
	wire logic hit = evt_i.div_zero | evt_i.misalign | evt_i.misalign_multi
		| evt_i.copro | evt_i.bad_pc | evt_i.bad_state | evt_i.undef
		| evt_i.escalate | evt_i.vec_fetch;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);
	a_wait_answer: assert property ((avs_read_i | avs_write_i)
		& avs_waitrequest_o |=> !avs_waitrequest_o)
		else $error("bus answer late");
	a_wait_pulse: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("wait low too long");
	a_undef_pc: assert property (evt_i.undef & !evt_i.vec_fetch |=>
		rsp_o.usage_take && rsp_o.stacked_pc == $past(evt_i.instr_pc))
		else $error("undef stack wrong");
	a_vec_pc: assert property (evt_i.vec_fetch |=> rsp_o.hard_take &&
		!rsp_o.usage_take && rsp_o.stacked_pc == $past(evt_i.preempt_pc))
		else $error("vector stack wrong");
	a_esc_hard: assert property (evt_i.escalate |=> rsp_o.hard_take)
		else $error("escalation lost");
	a_no_hard: assert property (!(evt_i.escalate | evt_i.vec_fetch)
		|=> !rsp_o.hard_take)
		else $error("spurious hard");
	a_pc_hold: assert property (!hit |=> $stable(rsp_o.stacked_pc))
		else $error("stacked pc moved");
	a_hf_rsvd: assert property (!avs_waitrequest_o && avs_read_i
		&& avs_address_i == FSC_HARD_FAULT_STATUS_OFS |-> !(avs_readdata_o & ~FSC_HARD_FAULT_STATUS_IMPL))
		else $error("reserved bit set");
endmodule : fsc_checker

bind fsc_fault_status fsc_checker u_chk (.clk_i(clk_i), .rst_n_i(rst_n_i),
	.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
	.avs_write_i(avs_write_i), .avs_readdata_o(avs_readdata_o),
	.avs_waitrequest_o(avs_waitrequest_o), .evt_i(evt_i), .rsp_o(rsp_o));

// *** verif/fsc_core_model.sv ***
`timescale 1ns/100ps
// ==========
// core fault reporter
module fsc_core_model
	import fsc_pkg::*;
(
	input wire logic clk_i,
	output fsc_evt_t evt_o
);
	initial evt_o = '0;
	// one-cycle pulse, addresses ride with the flag
	task automatic fire(input fsc_evt_t e);
		@(posedge clk_i);
		evt_o <= e;
		@(posedge clk_i);
		evt_o <= '0;
	endtask : fire
endmodule : fsc_core_model

// *** verif/test_fsc_fault_status.sv ***
`timescale 1ns/100ps
module test_fsc_fault_status import fsc_pkg::*;;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic [7:0]  avs_address_i = 8'h00;
	logic        avs_read_i = 1'b0;
	logic        avs_write_i = 1'b0;
	logic [3:0]  avs_byteenable_i = 4'hF;
	logic [31:0] avs_writedata_i = 32'h0;
	logic [31:0] avs_readdata_o;
	logic        avs_waitrequest_o;
	fsc_evt_t    evt_i;
	fsc_rsp_t    rsp_o;
	logic        dz_en;
	logic        ma_en;
	logic [31:0] rd;
	fsc_evt_t    e;
	int          errors = 0;
	int          cmp_count = 0;

	always #5 clk_i = ~clk_i;

	fsc_fault_status dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i),
		.avs_write_i(avs_write_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_writedata_i(avs_writedata_i), .avs_readdata_o(avs_readdata_o),
		.avs_waitrequest_o(avs_waitrequest_o), .evt_i(evt_i), .rsp_o(rsp_o),
		.div_zero_trap_en_o(dz_en), .misalign_trap_en_o(ma_en));
	fsc_core_model u_core (.clk_i(clk_i), .evt_o(evt_i));

	// ==========
	// tasks
	task automatic finish_test();
		if (errors == 0 && cmp_count > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : finish_test

	task automatic chk(input string n, input logic [31:0] x,
		input logic [31:0] g);
		cmp_count++;
		if (g !== x) begin
			errors++;
			$display("MISMATCH %s exp %h got %h", n, x, g);
		end
	endtask : chk

	// bounded wait, so a dead slave cannot hang the run
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [3:0] be, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_i);
		avs_address_i <= a;
		avs_byteenable_i <= be;
		avs_writedata_i <= d;
		avs_write_i <= w;
		avs_read_i <= !w;
		do begin
			@(posedge clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		if (n >= 50)
			errors++;
		rd = avs_readdata_o;
		avs_read_i <= 1'b0;
		avs_write_i <= 1'b0;
	endtask : bus

	task automatic rd_chk(input string n, input logic [7:0] a,
		input logic [31:0] m, input logic [31:0] x);
		bus(1'b0, a, 4'hF, 32'h0);
		chk(n, x, rd & m);
	endtask : rd_chk

	task automatic fire_f(input logic [9:0] f, input logic [31:0] pc);
		e = '0;
		{e.div_zero, e.misalign, e.misalign_multi, e.copro, e.bad_pc,
			e.bad_state, e.undef, e.escalate, e.vec_fetch, e.debug_evt} = f;
		e.instr_pc = pc;
		e.preempt_pc = ~pc;
		u_core.fire(e);
		#1;
	endtask : fire_f

	// ==========
	// tests
	initial begin
		repeat (2000) @(posedge clk_i);
		errors++;
		finish_test();
	end

	initial begin
		repeat (16) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rd_chk("config_fault_status", FSC_CONFIG_FAULT_STATUS_OFS, '1, 32'h0);
		rd_chk("hard_fault_status", FSC_HARD_FAULT_STATUS_OFS, '1, 32'h0);
		rd_chk("unmapped", 8'h40, '1, 32'h0);
		fire_f(10'h300, 32'h10);
		rd_chk("traps off", FSC_CONFIG_FAULT_STATUS_OFS, '1, 32'h0);
		fire_f(10'h080, 32'h14);
		rd_chk("multi", FSC_CONFIG_FAULT_STATUS_OFS, '1, 32'h0100_0000);
		bus(1'b1, FSC_CCR_OFS, 4'hF, 32'h0000_0018);
		repeat (2) @(posedge clk_i);
		chk("trap en", 32'h3, {30'h0, dz_en, ma_en});
		bus(1'b1, FSC_CONFIG_FAULT_STATUS_OFS, 4'hF, 32'hFFFF_FFFF);
		fire_f(10'h300, 32'h20);
		chk("div pc", 32'h20, rsp_o.stacked_pc);
		rd_chk("traps on", FSC_CONFIG_FAULT_STATUS_OFS, '1, 32'h0300_0000);
		for (int i = 0; i < 4; i++) begin
			fire_f(10'h040 >> i, 32'h100 + i);
			chk("pc", 32'h100 + i, rsp_o.stacked_pc);
			rd_chk("usage", FSC_CONFIG_FAULT_STATUS_OFS, '1,
				{16'h0300 | (16'h000F & (16'h000F << (3 - i))), 16'h0});
		end
		bus(1'b1, FSC_CONFIG_FAULT_STATUS_OFS, 4'hF, 32'h0200_0000);
		rd_chk("sticky", FSC_CONFIG_FAULT_STATUS_OFS, '1, 32'h010F_0000);
		bus(1'b1, FSC_CONFIG_FAULT_STATUS_OFS, 4'hC, 32'hFFFF_FFFF);
		rd_chk("half clr", FSC_CONFIG_FAULT_STATUS_OFS, '1, 32'h0);
		fire_f(10'h018, 32'h40);
		rd_chk("undef st", FSC_CONFIG_FAULT_STATUS_OFS, '1, 32'h0001_0000);
		bus(1'b1, FSC_CONFIG_FAULT_STATUS_OFS, 4'hF, 32'hFFFF_FFFF);
		fire_f(10'h004, 32'h30);
		fire_f(10'h002, 32'h2000);
		chk("vec pc", ~32'h2000, rsp_o.stacked_pc);
		rd_chk("hard", FSC_HARD_FAULT_STATUS_OFS, '1, 32'h4000_0002);
		bus(1'b1, FSC_HARD_FAULT_STATUS_OFS, 4'hF, 32'h4000_0000);
		rd_chk("hard clr", FSC_HARD_FAULT_STATUS_OFS, '1, 32'h0000_0002);
		e = '0;
		e.mm_cause = 8'h02;
		e.mm_addr_known = 1'b1;
		e.mm_addr = 32'h2000_0003;
		u_core.fire(e);
		rd_chk("memmanage_fault_address", FSC_MEMMANAGE_FAULT_ADDRESS_OFS, '1, 32'h2000_0003);
		rd_chk("mm valid", FSC_CONFIG_FAULT_STATUS_OFS, 32'h8080, 32'h0080);
		e = '0;
		e.bus_cause = 8'h02;
		e.bus_addr_known = 1'b1;
		e.bus_req_addr = 32'h2000_0001;
		u_core.fire(e);
		rd_chk("bus_fault_address", FSC_BUS_FAULT_ADDRESS_OFS, '1, 32'h2000_0001);
		rd_chk("bus valid", FSC_CONFIG_FAULT_STATUS_OFS, 32'h8080, 32'h8000);
		finish_test();
	end
endmodule : test_fsc_fault_status
